// >>> verilog/etb_core.v
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "etb_map.vh"
// emulator configuration block toward the target bus
module etb_core
(
    input wire CLOCK,
    input wire RESET_N,
    input wire [7:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output reg S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output reg S_AXI_WREADY,
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [7:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output reg S_AXI_ARREADY,
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY,
    input wire CYC_START,
    input wire CYC_EMU_MEM,
    input wire CYC_EXT_MODE,
    input wire CYC_DMA,
    input wire CYC_REFRESH,
    input wire CYC_DONE,
    input wire MAP_WIDTH16,
    input wire TARGET_READY,
    input wire BUS_WIDTH_INPUTS,
    input wire BACKGROUND,
    input wire HOLD_REQUEST_IN,
    input wire STEPPING,
    input wire NMI_ACCEPTED,
    input wire PAGE_UPDATE,
    input wire [31:0] PAGE_LIVE,
    output reg CYC_WAIT,
    output reg CYC_WIDTH16,
    output reg ADDR_EXT_OUT,
    output reg HOLD_ACK,
    output reg TRACE_CAPTURE,
    output reg MON_BREAK_REQ,
    output reg CONV_REJECT,
    output reg STEP_FAIL,
    output reg LOAD_EXTENDED,
    output reg [31:0] PAGE_COPY
);
    reg [31:0] cfg_r;
    reg [31:0] cfg_act_r;
    reg aw_got_r;
    reg w_got_r;
    reg [7:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg fg_ext_r;
    reg conv_pend_r;
    reg step_fail_r;

    wire [31:0] cfg_wr;
    wire wr_go;
    wire honour;
    wire use_tgt_width;
    wire ext_next;
    wire trace_next;
    wire hold_next;

    // byte-lane merge of a register word
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    merge[i*8 +: 8] = nw[i*8 +: 8];
        end
    endfunction

    assign wr_go = aw_got_r && w_got_r && !S_AXI_BVALID;
    assign cfg_wr = merge(cfg_r, w_data_r, w_strb_r) & `ETB_CFG_MASK;
    // the active copy only loads at cycle start so a cycle never sees a
    // setting change halfway through
    assign honour = cfg_act_r[`ETB_B_HONOUR];
    assign use_tgt_width = CYC_EMU_MEM ? cfg_act_r[`ETB_B_EBS_TGT]
                                       : cfg_act_r[`ETB_B_TBS_TGT];
    assign ext_next = cfg_act_r[`ETB_B_HOLD_LAST] ? fg_ext_r
                                                  : CYC_EXT_MODE;
    assign trace_next = CYC_DMA ? cfg_act_r[`ETB_B_TDMA]
                      : CYC_REFRESH ? cfg_act_r[`ETB_B_TREF]
                      : 1'b1;
    assign hold_next = BACKGROUND ? (cfg_act_r[`ETB_B_BGHOLD] && HOLD_REQUEST_IN)
                                  : HOLD_REQUEST_IN;

    always @(posedge CLOCK)
    begin
        if (!RESET_N)
        begin
            cfg_r <= `ETB_CFG_RESET;
            cfg_act_r <= `ETB_CFG_RESET;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= 2'b00;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RRESP <= 2'b00;
            S_AXI_RDATA <= 32'h0000_0000;
            fg_ext_r <= 1'b0;
            conv_pend_r <= 1'b0;
            step_fail_r <= 1'b0;
            CYC_WAIT <= 1'b0;
            CYC_WIDTH16 <= 1'b0;
            ADDR_EXT_OUT <= 1'b0;
            HOLD_ACK <= 1'b0;
            TRACE_CAPTURE <= 1'b0;
            MON_BREAK_REQ <= 1'b0;
            CONV_REJECT <= 1'b0;
            STEP_FAIL <= 1'b0;
            LOAD_EXTENDED <= 1'b1;
            PAGE_COPY <= 32'h0000_0000;
        end
        else
        begin
            // write channel: address and data taken in either order
            S_AXI_AWREADY <= !aw_got_r && !S_AXI_AWREADY && S_AXI_AWVALID;
            S_AXI_WREADY <= !w_got_r && !S_AXI_WREADY && S_AXI_WVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_got_r <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_got_r <= 1'b1;
                w_data_r <= S_AXI_WDATA;
                w_strb_r <= S_AXI_WSTRB;
            end
            conv_pend_r <= 1'b0;
            if (wr_go)
            begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= 2'b00;
                case (aw_addr_r)
                    `ETB_CFG_ADDR: cfg_r <= cfg_wr;
                    `ETB_PAGE_ADDR: PAGE_COPY <= merge(PAGE_COPY, w_data_r,
                                                       w_strb_r);
                    `ETB_CMD_ADDR: conv_pend_r <= w_data_r[0];
                    `ETB_STAT_ADDR: S_AXI_BRESP <= 2'b00;
                    default: S_AXI_BRESP <= 2'b10;
                endcase
            end
            else if (S_AXI_BVALID && S_AXI_BREADY)
                S_AXI_BVALID <= 1'b0;

            // read channel
            S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY)
            begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= 2'b00;
                case (S_AXI_ARADDR)
                    `ETB_CFG_ADDR: S_AXI_RDATA <= cfg_r;
                    `ETB_STAT_ADDR: S_AXI_RDATA <= {26'h0, step_fail_r,
                        CONV_REJECT, MON_BREAK_REQ, fg_ext_r,
                        HOLD_ACK, ADDR_EXT_OUT};
                    `ETB_PAGE_ADDR: S_AXI_RDATA <= PAGE_COPY;
                    `ETB_CMD_ADDR: S_AXI_RDATA <= 32'h0000_0000;
                    default:
                    begin
                        S_AXI_RDATA <= 32'h0000_0000;
                        S_AXI_RRESP <= 2'b10;
                    end
                endcase
            end
            else if (S_AXI_RVALID && S_AXI_RREADY)
                S_AXI_RVALID <= 1'b0;

            if (CYC_START)
                cfg_act_r <= cfg_r;

            if (!BACKGROUND && CYC_START)
                fg_ext_r <= CYC_EXT_MODE;

            // a conversion request: reject, break for live pages, or use copy
            if (conv_pend_r)
            begin
                if (cfg_act_r[`ETB_B_REFETCH] && cfg_act_r[`ETB_B_RRT])
                    CONV_REJECT <= 1'b1;
                else if (cfg_act_r[`ETB_B_REFETCH])
                    MON_BREAK_REQ <= 1'b1;
                else
                    CONV_REJECT <= 1'b0;
            end
            else if (wr_go && aw_addr_r == `ETB_STAT_ADDR)
            begin
                CONV_REJECT <= 1'b0;
            end
            if (PAGE_UPDATE)
            begin
                PAGE_COPY <= PAGE_LIVE;
                MON_BREAK_REQ <= 1'b0;
            end

            // set wins over a software clear of the failure flag
            if (STEPPING && NMI_ACCEPTED)
                step_fail_r <= 1'b1;
            else if (wr_go && aw_addr_r == `ETB_STAT_ADDR && w_data_r[5])
                step_fail_r <= 1'b0;
            STEP_FAIL <= STEPPING && NMI_ACCEPTED;

            CYC_WAIT <= CYC_EMU_MEM ? (honour && !TARGET_READY)
                                    : !TARGET_READY;
            CYC_WIDTH16 <= use_tgt_width ? BUS_WIDTH_INPUTS
                                         : MAP_WIDTH16;
            ADDR_EXT_OUT <= BACKGROUND ? ext_next : CYC_EXT_MODE;
            HOLD_ACK <= hold_next;
            TRACE_CAPTURE <= CYC_DONE && trace_next;
            LOAD_EXTENDED <= !cfg_act_r[`ETB_B_LAD_PHY];
        end
    end
endmodule // etb_core
`default_nettype wire

// >>> verilog/etb_map.vh
`ifndef ETB_MAP_VH
`define ETB_MAP_VH
`define ETB_CFG_ADDR 8'h00
`define ETB_STAT_ADDR 8'h04
`define ETB_PAGE_ADDR 8'h08
`define ETB_CMD_ADDR 8'h0c
`define ETB_B_HONOUR 0
`define ETB_B_EBS_TGT 1
`define ETB_B_TBS_TGT 2
`define ETB_B_REFETCH 3
`define ETB_B_RRT 4
`define ETB_B_HOLD_LAST 5
`define ETB_B_BGHOLD 6
`define ETB_B_TDMA 7
`define ETB_B_TREF 8
`define ETB_B_LAD_PHY 9
`define ETB_CFG_RESET 32'h0000_0184
`define ETB_CFG_MASK 32'h0000_03ff
`endif

// >>> test/etb_chk.sv
`timescale 1ns/1ps
`default_nettype none
module etb_chk
(
    input wire CLOCK,
    input wire RESET_N,
    input wire CYC_EMU_MEM,
    input wire TARGET_READY,
    input wire CYC_WAIT,
    input wire CYC_DONE,
    input wire CYC_DMA,
    input wire CYC_REFRESH,
    input wire TRACE_CAPTURE,
    input wire BACKGROUND,
    input wire HOLD_REQUEST_IN,
    input wire HOLD_ACK,
    input wire CYC_EXT_MODE,
    input wire ADDR_EXT_OUT,
    input wire STEPPING,
    input wire NMI_ACCEPTED,
    input wire STEP_FAIL,
    input wire LOAD_EXTENDED
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    // target memory cycles wait on a busy target whatever the setting
    property p_tgt; !CYC_EMU_MEM && !TARGET_READY |=> CYC_WAIT; endproperty
    a_tgt: assert property (p_tgt) else $error("no wait on target");
    property p_wcause; CYC_WAIT |-> $past(!TARGET_READY); endproperty
    a_wcause: assert property (p_wcause) else $error("wait while ready");
    property p_tcause; TRACE_CAPTURE |-> $past(CYC_DONE); endproperty
    a_tcause: assert property (p_tcause) else $error("stray capture");
    property p_tplain; CYC_DONE && !CYC_DMA && !CYC_REFRESH |=> TRACE_CAPTURE;
    endproperty
    a_tplain: assert property (p_tplain) else $error("cycle not traced");
    property p_hold; !BACKGROUND |=> HOLD_ACK == $past(HOLD_REQUEST_IN);
    endproperty
    a_hold: assert property (p_hold) else $error("hold not passed");
    property p_aex; !BACKGROUND |=> ADDR_EXT_OUT == $past(CYC_EXT_MODE);
    endproperty
    a_aex: assert property (p_aex) else $error("extension wrong");
    property p_nmi; STEPPING && NMI_ACCEPTED |=> STEP_FAIL; endproperty
    a_nmi: assert property (p_nmi) else $error("step not failed");
    property p_sf; STEP_FAIL |-> $past(STEPPING && NMI_ACCEPTED); endproperty
    a_sf: assert property (p_sf) else $error("stray step fail");
    property p_rst; $rose(RESET_N) |-> LOAD_EXTENDED; endproperty
    a_rst: assert property (p_rst) else $error("load kind reset");
    c_wait: cover property (CYC_WAIT);
    c_trc: cover property (TRACE_CAPTURE);
    c_sf: cover property (STEP_FAIL);
endmodule // etb_chk
bind etb_core etb_chk u_etb_chk(.*);
`default_nettype wire

// >>> test/etb_tgt.sv
`timescale 1ns/1ps
`default_nettype none
// target side: a slow target holds ready low for the whole cycle
module etb_tgt
(
    input wire slow,
    input wire w16,
    output wire TARGET_READY,
    output wire BUS_WIDTH_INPUTS
);
    assign TARGET_READY = !slow;
    assign BUS_WIDTH_INPUTS = w16;
endmodule // etb_tgt
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
logic CLOCK = 0, RESET_N = 0, slow = 0, w16 = 0;
logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
logic [31:0] S_AXI_WDATA = 0, PAGE_LIVE = 0, rd;
logic [3:0] S_AXI_WSTRB = 4'hf;
logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0, CYC_START = 0, CYC_EMU_MEM = 0;
logic CYC_EXT_MODE = 0, CYC_DMA = 0, CYC_REFRESH = 0, CYC_DONE = 0;
logic MAP_WIDTH16 = 0, BACKGROUND = 0, HOLD_REQUEST_IN = 0, STEPPING = 0;
logic NMI_ACCEPTED = 0, PAGE_UPDATE = 0, t;
logic [1:0] rr;
wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
wire [31:0] S_AXI_RDATA, PAGE_COPY;
wire CYC_WAIT, CYC_WIDTH16, ADDR_EXT_OUT, HOLD_ACK, TRACE_CAPTURE, STEP_FAIL;
wire MON_BREAK_REQ, CONV_REJECT, LOAD_EXTENDED, TARGET_READY, BUS_WIDTH_INPUTS;
int bad_count = 0, check_count = 0;
logic [17:0] tab [6] = '{{10'h001, 8'b01101111}, {10'h080, 8'b11110001},
    {10'h002, 8'b11010010}, {10'h002, 8'b01001001},
    {10'h004, 8'b00010011}, {10'h000, 8'b00110101}};
etb_core u_etb_core(.*);
etb_tgt u_etb_tgt(.slow(slow), .w16(w16), .TARGET_READY(TARGET_READY),
    .BUS_WIDTH_INPUTS(BUS_WIDTH_INPUTS));
always #2.5 CLOCK = ~CLOCK;
task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
        bad_count++;
        $display("[ERR] %s exp %h got %h", n, e, s);
    end
endtask
task axw(input logic [7:0] a, input logic [31:0] d);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    while (S_AXI_BVALID !== 1'b1)
    begin
        @(posedge CLOCK);
        if (S_AXI_AWREADY === 1'b1)
            S_AXI_AWVALID <= 1'b0;
        if (S_AXI_WREADY === 1'b1)
            S_AXI_WVALID <= 1'b0;
    end
    S_AXI_BREADY <= 1'b0;
    @(posedge CLOCK);
endtask
task axr(input logic [7:0] a);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    while (S_AXI_RVALID !== 1'b1)
    begin
        @(posedge CLOCK);
        if (S_AXI_ARREADY === 1'b1)
            S_AXI_ARVALID <= 1'b0;
    end
    rd = S_AXI_RDATA;
    rr = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
    @(posedge CLOCK);
endtask
// new settings reach the outputs only through a fresh bus cycle
task cyc(input logic [17:0] v);
    axw(8'h00, {22'h0, v[17:8]});
    CYC_START <= 1'b1;
    {CYC_DMA, CYC_EMU_MEM, slow, w16, MAP_WIDTH16} <= v[7:3];
    @(posedge CLOCK);
    CYC_START <= 1'b0;
    CYC_DONE <= 1'b1;
    @(posedge CLOCK);
    CYC_DONE <= 1'b0;
    @(posedge CLOCK);
    t = TRACE_CAPTURE;
endtask
task stop_test;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask
initial
begin
    #20000;
    bad_count++;
    stop_test;
end
initial
begin
    repeat (2) @(posedge CLOCK);
    RESET_N <= 1'b1;
    @(posedge CLOCK);
    axr(8'h00);
    chk("cfg", rd, 32'h0000_0184);
    axr(8'h10);
    chk("bad", {rr, rd[29:0]}, 32'h8000_0000);
    for (int i = 0; i < 6; i++)
    begin
        cyc(tab[i]);
        chk("out", {CYC_WAIT, CYC_WIDTH16, t}, tab[i][2:0]);
    end
    cyc({10'h018, 8'h00});
    axw(8'h0c, 32'h1);
    repeat (2) @(posedge CLOCK);
    chk("rej", CONV_REJECT, 1'b1);
    cyc({10'h008, 8'h00});
    axw(8'h0c, 32'h1);
    repeat (2) @(posedge CLOCK);
    chk("brk", MON_BREAK_REQ, 1'b1);
    PAGE_UPDATE <= 1'b1;
    PAGE_LIVE <= 32'h1234_5678;
    @(posedge CLOCK);
    PAGE_UPDATE <= 1'b0;
    repeat (2) @(posedge CLOCK);
    chk("page", PAGE_COPY, 32'h1234_5678);
    STEPPING <= 1'b1;
    NMI_ACCEPTED <= 1'b1;
    @(posedge CLOCK);
    NMI_ACCEPTED <= 1'b0;
    @(posedge CLOCK);
    chk("step", STEP_FAIL, 1'b1);
    BACKGROUND <= 1'b1;
    HOLD_REQUEST_IN <= 1'b1;
    repeat (3) @(posedge CLOCK);
    chk("hold", HOLD_ACK, 1'b0);
    STEPPING <= 1'b0;
    BACKGROUND <= 1'b0;
    // hold-last, background hold on, refresh untraced, physical load kind
    axw(8'h00, 32'h0000_0260);
    CYC_EXT_MODE <= 1'b1;
    CYC_START <= 1'b1;
    @(posedge CLOCK);
    {CYC_START, CYC_EXT_MODE, BACKGROUND} <= 3'b001;
    {CYC_REFRESH, CYC_DONE} <= 2'b11;
    repeat (2) @(posedge CLOCK);
    chk("aexh", ADDR_EXT_OUT, 1'b1);
    chk("bgh", HOLD_ACK, 1'b1);
    chk("trf0", TRACE_CAPTURE, 1'b0);
    chk("lad", LOAD_EXTENDED, 1'b0);
    CYC_DONE <= 1'b0;
    // follow-mode: a normal-mode background cycle must not keep the old level
    axw(8'h00, 32'h0000_0100);
    {CYC_START, CYC_DONE} <= 2'b11;
    @(posedge CLOCK);
    CYC_START <= 1'b0;
    repeat (2) @(posedge CLOCK);
    chk("aexf", ADDR_EXT_OUT, 1'b0);
    chk("bgi", HOLD_ACK, 1'b0);
    chk("trf1", TRACE_CAPTURE, 1'b1);
    CYC_DONE <= 1'b0;
    stop_test;
end
endmodule // tb
`default_nettype wire
